//--- rtl/sftr_pkg.sv
// constants for the frame timing configuration bank
`default_nettype none
package sftr_pkg;
    // ****************************************
    // addressing
    // ****************************************
    localparam int          ADDR_W           = 9;
    localparam int          DATA_W           = 16;
    localparam logic [8:0]  BANK_BASE        = 9'h0C0;
    localparam logic [8:0]  OFS_INTEG_CTRL   = 9'h002;
    localparam logic [8:0]  OFS_REGION_UPPER = 9'h004;
    localparam logic [8:0]  OFS_DARK_ROW     = 9'h005;
    localparam logic [8:0]  OFS_PADDING_ROW  = 9'h006;
    localparam logic [8:0]  OFS_TICK_MULT    = 9'h007;
    localparam logic [8:0]  OFS_PERIOD_LEN   = 9'h008;
    localparam logic [8:0]  OFS_INTEG_TIME   = 9'h009;
    localparam logic [8:0]  OFS_SPARE_A      = 9'h00A;
    localparam logic [8:0]  OFS_SPARE_B      = 9'h00B;
    localparam logic [8:0]  OFS_GAIN_SETUP   = 9'h00C;
    localparam logic [8:0]  OFS_SYNC_CFG     = 9'h00E;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RST_INTEG_CTRL   = 16'h0004;
    localparam logic [15:0] RST_REGION_UPPER = 16'h0000;
    localparam logic [15:0] RST_DARK_ROW     = 16'h0102;
    localparam logic [15:0] RST_PADDING_ROW  = 16'h0000;
    localparam logic [15:0] RST_TICK_MULT    = 16'h0001;
    localparam logic [15:0] RST_PERIOD_LEN   = 16'h0000;
    localparam logic [15:0] RST_INTEG_TIME   = 16'h0000;
    localparam logic [15:0] RST_GAIN_SETUP   = 16'h01E2;
    localparam logic [15:0] RST_SYNC_CFG     = 16'h033F;
    // ****************************************
    // field positions
    // ****************************************
    localparam int          POS_PERIOD_MEANING = 2;
    localparam int          POS_REGION_LO      = 7;
    localparam int          POS_REGION_HI      = 15;
    localparam int          POS_BLANK_FIRST    = 8;
    localparam int          POS_SYNC_DARK      = 1;
    localparam int          POS_SYNC_PADDING   = 2;
    localparam int          POS_SYNC_EXPOSURE  = 3;
    localparam int          POS_SYNC_REGION    = 5;
    localparam logic [7:0]  DARK_ROW_MIN       = 8'h01;
    // ****************************************
    // time base: one tick unit is one base cycle times the multiplier
    // ****************************************
    localparam int          BASE_RATE_MHZ    = 62;
    localparam int          CLK_RATE_MHZ     = 25;
    // each clock adds its length in base cycles; one base cycle costs CLK_PER_UNIT
    localparam logic [23:0] ACC_STEP         = 24'(BASE_RATE_MHZ);
    localparam logic [7:0]  CLK_PER_UNIT     = 8'(CLK_RATE_MHZ);
    typedef enum logic [1:0] {
        GS_IDLE   = 2'b00,
        GS_RESET  = 2'b01,
        GS_EXPOSE = 2'b10,
        GS_HOLD   = 2'b11
    } sftr_gs_state_e;
endpackage
`default_nettype wire

//--- rtl/sftr_gs_if.sv
// carrier between the bank and its global shutter timer
`default_nettype none
interface sftr_gs_if;
    logic [15:0] tick_mult;
    logic [15:0] period_len;
    logic [15:0] integ_time;
    logic        period_is_frame;
    logic        start;
    logic        tick;
    logic        exposing;
    logic        period_done;
    modport ctrl  (output tick_mult, period_len, integ_time, period_is_frame, start,
                   input tick, exposing, period_done);
    modport timer (input tick_mult, period_len, integ_time, period_is_frame, start,
                   output tick, exposing, period_done);
endinterface
`default_nettype wire

//--- rtl/sftr_gs_timer.sv
// global shutter tick base and exposure/period sequencer
`default_nettype none
module sftr_gs_timer
    import sftr_pkg::*;
(
    // clock and reset
    input  wire logic  clk,
    input  wire logic  srst,
    // timing carrier
    sftr_gs_if.timer   gs
);
    logic [23:0]    acc_reg;
    logic [23:0]    thr;
    logic [24:0]    acc_sum;
    logic [24:0]    acc_rem;
    logic           unit_tick;
    logic [15:0]    per_cnt_reg;
    logic [15:0]    exp_cnt_reg;
    sftr_gs_state_e state_reg;
    logic           tick_reg;
    logic           exposing_reg;
    logic           done_reg;

    // ****************************************
    // unit tick: mult base cycles, fractional from the 25 MHz clock
    // ****************************************
    always_comb begin
        thr       = 24'(CLK_PER_UNIT) * 24'((gs.tick_mult == 16'h0000) ? 16'h0001 : gs.tick_mult); // RULE_05
        acc_sum   = {1'b0, acc_reg} + {1'b0, ACC_STEP};
        acc_rem   = acc_sum - {1'b0, thr};
        unit_tick = (acc_sum >= {1'b0, thr});
    end

    // exact average for units of a clock or longer; shorter units saturate at one tick per clock
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_reg  <= 24'h000000;
            tick_reg <= 1'b0;
        end else begin
            acc_reg  <= unit_tick ? ((acc_rem >= {1'b0, thr}) ? (thr - 24'h000001) : acc_rem[23:0]) : acc_sum[23:0];
            tick_reg <= unit_tick;
        end
    end

    // ****************************************
    // sequence
    // ****************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg    <= GS_IDLE;
            per_cnt_reg  <= 16'h0000;
            exp_cnt_reg  <= 16'h0000;
            exposing_reg <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            case (state_reg)
                GS_IDLE: begin
                    exposing_reg <= 1'b0;
                    if (gs.start) begin
                        per_cnt_reg <= gs.period_len;
                        exp_cnt_reg <= gs.integ_time; // RULE_07
                        if (gs.period_is_frame) begin // RULE_06
                            state_reg    <= GS_EXPOSE;
                            exposing_reg <= 1'b1;
                        end else begin
                            state_reg <= GS_RESET;
                        end
                    end
                end
                GS_RESET: begin
                    // exposure follows the done pulse by one cycle
                    if (per_cnt_reg == 16'h0000) begin // RULE_06
                        state_reg    <= GS_EXPOSE;
                        done_reg     <= 1'b1;
                    end else if (tick_reg) begin
                        per_cnt_reg <= per_cnt_reg - 16'h0001;
                    end
                end
                GS_EXPOSE: begin
                    exposing_reg <= 1'b1; // RULE_07
                    if (tick_reg && gs.period_is_frame && per_cnt_reg != 16'h0000) begin
                        per_cnt_reg <= per_cnt_reg - 16'h0001;
                    end
                    if (exp_cnt_reg == 16'h0000) begin
                        exposing_reg <= 1'b0;
                        state_reg    <= gs.period_is_frame ? GS_HOLD : GS_IDLE;
                    end else if (tick_reg) begin
                        exp_cnt_reg <= exp_cnt_reg - 16'h0001;
                    end
                end
                GS_HOLD: begin
                    if (per_cnt_reg == 16'h0000) begin // RULE_06
                        state_reg <= GS_IDLE;
                        done_reg  <= 1'b1;
                    end else if (tick_reg) begin
                        per_cnt_reg <= per_cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= GS_IDLE;
                end
            endcase
        end
    end

    assign gs.tick        = tick_reg;
    assign gs.exposing    = exposing_reg;
    assign gs.period_done = done_reg;
endmodule
`default_nettype wire

//--- rtl/sftr_frame_timing_regs.sv
// sequencer frame timing configuration bank with start-of-frame apply
// What this block does
// [RULE_01] upper bits 7-15 enable regions 23-31
// [RULE_02] dark row count 1-255, reset two
// [RULE_03] blank-first-line bit, resets to one
// [RULE_04] padding rows 0-4095, rolling shutter only
// [RULE_05] tick multiplier sets global shutter time unit
// [RULE_06] period is reset or frame length
// [RULE_07] exposure in lines or tick units
// [RULE_08] period meaning select resets to frame
// [RULE_09] sync bits defer updates to frame start
// [RULE_10] software writes zero to reserved places
`default_nettype none
module sftr_frame_timing_regs
    import sftr_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        SRST,
    // configuration access from the serial decoder
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [8:0]  CFG_ADDR,
    input  wire logic [15:0] CFG_WDATA,
    output var  logic [15:0] CFG_RDATA,
    output var  logic        CFG_RVALID,
    // sequencer status
    input  wire logic        FRAME_START,
    input  wire logic        GLOBAL_SHUTTER,
    input  wire logic        GS_START,
    // applied configuration
    output var  logic [8:0]  REGION_ENABLE_UPPER,
    output var  logic [7:0]  DARK_ROWS,
    output var  logic        BLANK_FIRST_LINE,
    output var  logic [11:0] PADDING_ROWS,
    output var  logic [15:0] INTEGRATION_TIME,
    output var  logic [15:0] PERIOD_LENGTH,
    output var  logic        PERIOD_IS_FRAME,
    output var  logic [15:0] TICK_MULT,
    output var  logic [4:0]  COLUMN_GAIN,
    // global shutter timing
    output var  logic        GS_TICK,
    output var  logic        GS_EXPOSING,
    output var  logic        GS_PERIOD_DONE
);
    logic [15:0] integ_ctrl_reg;
    logic [15:0] region_upper_reg;
    logic [15:0] dark_row_reg;
    logic [15:0] padding_row_reg;
    logic [15:0] tick_mult_reg;
    logic [15:0] period_len_reg;
    logic [15:0] integ_time_reg;
    logic [15:0] gain_setup_reg;
    logic [15:0] sync_cfg_reg;
    logic [8:0]  ofs;
    logic        in_bank;
    logic [15:0] rd_next;
    logic        apply_dark;
    logic        apply_pad;
    logic        apply_exp;
    logic        apply_region;
    logic        start_reg;

    sftr_gs_if gs_bus ();

    // ****************************************
    // decode
    // ****************************************
    always_comb begin
        ofs     = 9'(CFG_ADDR - BANK_BASE);
        in_bank = (CFG_ADDR >= BANK_BASE);
    end

    // ****************************************
    // software-visible registers
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            integ_ctrl_reg   <= RST_INTEG_CTRL; // RULE_08
            region_upper_reg <= RST_REGION_UPPER; // RULE_01
            dark_row_reg     <= RST_DARK_ROW; // RULE_02 RULE_03
            padding_row_reg  <= RST_PADDING_ROW;
            tick_mult_reg    <= RST_TICK_MULT;
            period_len_reg   <= RST_PERIOD_LEN;
            integ_time_reg   <= RST_INTEG_TIME;
            gain_setup_reg   <= RST_GAIN_SETUP;
            sync_cfg_reg     <= RST_SYNC_CFG;
        end else if (CFG_WR && in_bank) begin
            case (ofs)
                OFS_INTEG_CTRL:   integ_ctrl_reg   <= CFG_WDATA & RST_INTEG_CTRL; // RULE_08
                OFS_REGION_UPPER: region_upper_reg <= CFG_WDATA;
                OFS_DARK_ROW:     dark_row_reg     <= {7'h00, CFG_WDATA[8:0]};
                OFS_PADDING_ROW:  padding_row_reg  <= {4'h0, CFG_WDATA[11:0]};
                OFS_TICK_MULT:    tick_mult_reg    <= CFG_WDATA;
                OFS_PERIOD_LEN:   period_len_reg   <= CFG_WDATA;
                OFS_INTEG_TIME:   integ_time_reg   <= CFG_WDATA;
                OFS_GAIN_SETUP:   gain_setup_reg   <= CFG_WDATA;
                OFS_SYNC_CFG:     sync_cfg_reg     <= CFG_WDATA;
                // spare words keep no state; writes land nowhere
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // readback
    // ****************************************
    always_comb begin
        rd_next = 16'h0000;
        if (in_bank) begin
            case (ofs)
                OFS_INTEG_CTRL:   rd_next = integ_ctrl_reg;
                OFS_REGION_UPPER: rd_next = region_upper_reg;
                OFS_DARK_ROW:     rd_next = dark_row_reg;
                OFS_PADDING_ROW:  rd_next = padding_row_reg;
                OFS_TICK_MULT:    rd_next = tick_mult_reg;
                OFS_PERIOD_LEN:   rd_next = period_len_reg;
                OFS_INTEG_TIME:   rd_next = integ_time_reg;
                OFS_GAIN_SETUP:   rd_next = gain_setup_reg;
                OFS_SYNC_CFG:     rd_next = sync_cfg_reg;
                // spare words read as zero, software must not rely on them
                default:          rd_next = 16'h0000; // RULE_10
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CFG_RDATA  <= 16'h0000;
            CFG_RVALID <= 1'b0;
        end else begin
            CFG_RVALID <= CFG_RD;
            if (CFG_RD) begin
                CFG_RDATA <= rd_next;
            end
        end
    end

    // ****************************************
    // apply: at frame start while synced, at once otherwise
    // ****************************************
    always_comb begin
        apply_dark   = FRAME_START || !sync_cfg_reg[POS_SYNC_DARK]; // RULE_09
        apply_pad    = FRAME_START || !sync_cfg_reg[POS_SYNC_PADDING]; // RULE_09
        apply_exp    = FRAME_START || !sync_cfg_reg[POS_SYNC_EXPOSURE]; // RULE_09
        apply_region = FRAME_START || !sync_cfg_reg[POS_SYNC_REGION]; // RULE_09
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            REGION_ENABLE_UPPER <= RST_REGION_UPPER[POS_REGION_HI:POS_REGION_LO];
        end else if (apply_region) begin
            REGION_ENABLE_UPPER <= region_upper_reg[POS_REGION_HI:POS_REGION_LO]; // RULE_01
        end
    end

    // a zero count is outside the legal range; one row is the safe floor
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DARK_ROWS        <= RST_DARK_ROW[7:0];
            BLANK_FIRST_LINE <= RST_DARK_ROW[POS_BLANK_FIRST];
        end else if (apply_dark) begin
            DARK_ROWS        <= (dark_row_reg[7:0] == 8'h00) ? DARK_ROW_MIN : dark_row_reg[7:0]; // RULE_02
            BLANK_FIRST_LINE <= dark_row_reg[POS_BLANK_FIRST]; // RULE_03
        end
    end

    logic [11:0] pad_held_reg;
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pad_held_reg <= RST_PADDING_ROW[11:0];
            PADDING_ROWS <= RST_PADDING_ROW[11:0];
        end else begin
            if (apply_pad) begin
                pad_held_reg <= padding_row_reg[11:0];
            end
            PADDING_ROWS <= GLOBAL_SHUTTER ? 12'h000 : pad_held_reg; // RULE_04
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            INTEGRATION_TIME <= RST_INTEG_TIME;
            PERIOD_LENGTH    <= RST_PERIOD_LEN;
            PERIOD_IS_FRAME  <= RST_INTEG_CTRL[POS_PERIOD_MEANING];
            TICK_MULT        <= RST_TICK_MULT;
        end else if (apply_exp) begin
            INTEGRATION_TIME <= integ_time_reg; // RULE_07
            PERIOD_LENGTH    <= period_len_reg; // RULE_06
            PERIOD_IS_FRAME  <= integ_ctrl_reg[POS_PERIOD_MEANING]; // RULE_08
            TICK_MULT        <= tick_mult_reg; // RULE_05
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            COLUMN_GAIN <= RST_GAIN_SETUP[4:0];
        end else begin
            COLUMN_GAIN <= gain_setup_reg[4:0];
        end
    end

    // ****************************************
    // global shutter timing
    // ****************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            start_reg <= 1'b0;
        end else begin
            start_reg <= GS_START && GLOBAL_SHUTTER; // RULE_05
        end
    end

    assign gs_bus.tick_mult       = TICK_MULT;
    assign gs_bus.period_len      = PERIOD_LENGTH;
    assign gs_bus.integ_time      = INTEGRATION_TIME;
    assign gs_bus.period_is_frame = PERIOD_IS_FRAME;
    assign gs_bus.start           = start_reg;

    sftr_gs_timer u_timer (
        .clk  (CLK),
        .srst (SRST),
        .gs   (gs_bus.timer)
    );

    always_ff @(posedge CLK) begin
        if (SRST) begin
            GS_TICK        <= 1'b0;
            GS_EXPOSING    <= 1'b0;
            GS_PERIOD_DONE <= 1'b0;
        end else begin
            GS_TICK        <= gs_bus.tick;
            GS_EXPOSING    <= gs_bus.exposing;
            GS_PERIOD_DONE <= gs_bus.period_done;
        end
    end
endmodule
`default_nettype wire

//--- test/sftr_ftr_monitor.sv
// port assertions for the frame timing configuration bank
`default_nettype none
module sftr_ftr_monitor
    import sftr_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        SRST,
    // configuration access
    input wire logic        CFG_RD,
    input wire logic [8:0]  CFG_ADDR,
    input wire logic [15:0] CFG_RDATA,
    input wire logic        CFG_RVALID,
    // applied configuration and timing
    input wire logic        GLOBAL_SHUTTER,
    input wire logic [8:0]  REGION_ENABLE_UPPER,
    input wire logic [7:0]  DARK_ROWS,
    input wire logic        BLANK_FIRST_LINE,
    input wire logic [11:0] PADDING_ROWS,
    input wire logic        PERIOD_IS_FRAME,
    input wire logic [15:0] TICK_MULT,
    input wire logic        GS_TICK,
    input wire logic        GS_PERIOD_DONE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // ****************************************
    // assertions
    // ****************************************
    property p_rd_answer;
        CFG_RD |=> CFG_RVALID;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_hold;
        !CFG_RD |=> !CFG_RVALID && $stable(CFG_RDATA);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
    property p_spare_zero;
        CFG_RD && (CFG_ADDR == BANK_BASE + OFS_SPARE_A || CFG_ADDR == BANK_BASE + OFS_SPARE_B)
            |=> CFG_RDATA == 16'h0000;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare word not zero");
    property p_dark_bits;
        CFG_RD && CFG_ADDR == BANK_BASE + OFS_DARK_ROW |=> CFG_RDATA[15:9] == 7'h00;
    endproperty
    a_dark_bits: assert property (p_dark_bits) else $error("dark row upper bits set");
    property p_dark_min;
        DARK_ROWS != 8'h00;
    endproperty
    a_dark_min: assert property (p_dark_min) else $error("dark rows zero");
    property p_rst_dark;
        $fell(SRST) |-> DARK_ROWS == 8'h02 && BLANK_FIRST_LINE && PADDING_ROWS == 12'h000;
    endproperty
    a_rst_dark: assert property (p_rst_dark) else $error("row reset values wrong");
    property p_rst_gs;
        $fell(SRST) |-> PERIOD_IS_FRAME && TICK_MULT == 16'h0001 && REGION_ENABLE_UPPER == 9'h000;
    endproperty
    a_rst_gs: assert property (p_rst_gs) else $error("timing reset values wrong");
    property p_pad_gs;
        GLOBAL_SHUTTER && $past(GLOBAL_SHUTTER) && $past(GLOBAL_SHUTTER, 2) |-> PADDING_ROWS == 12'h000;
    endproperty
    a_pad_gs: assert property (p_pad_gs) else $error("padding rows in global shutter");
    property p_tick_gap;
        $past(TICK_MULT) >= 16'h0005 && $past(TICK_MULT) == $past(TICK_MULT, 2)
            && $past(TICK_MULT, 2) == $past(TICK_MULT, 3) && GS_TICK |=> !GS_TICK;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("ticks closer than the unit allows");
    property p_done_pulse;
        GS_PERIOD_DONE |=> !GS_PERIOD_DONE;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("period done too long");
    c_read: cover property (CFG_RD ##1 CFG_RVALID);
    c_tick: cover property (GS_TICK);
    c_done: cover property (GS_PERIOD_DONE);
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the frame timing configuration bank
`default_nettype none
module tb;
    import sftr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK = 0, SRST = 1, CFG_WR = 0, CFG_RD = 0, FRAME_START = 0, GLOBAL_SHUTTER = 0, GS_START = 0;
    logic [8:0]  CFG_ADDR = 9'h000;
    logic [15:0] CFG_WDATA = 16'h0000;
    wire logic [15:0] CFG_RDATA, INTEGRATION_TIME, PERIOD_LENGTH, TICK_MULT;
    wire logic [8:0]  REGION_ENABLE_UPPER;
    wire logic [7:0]  DARK_ROWS;
    wire logic [11:0] PADDING_ROWS;
    wire logic [4:0]  COLUMN_GAIN;
    wire logic        CFG_RVALID, BLANK_FIRST_LINE, PERIOD_IS_FRAME, GS_TICK, GS_EXPOSING, GS_PERIOD_DONE;
    int          errors = 0, num_checks = 0;
    int          offs [11] = '{2, 4, 5, 6, 7, 8, 9, 'hA, 'hB, 'hC, 'hE};
    logic [15:0] mdl [int];
    logic [15:0] hold_d, hold_i;
    int          tall, tex, tdone, tfirst, tlast, cyc, tprev;
    sftr_frame_timing_regs uut (.CLK, .SRST, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA, .CFG_RVALID,
        .FRAME_START, .GLOBAL_SHUTTER, .GS_START, .REGION_ENABLE_UPPER, .DARK_ROWS, .BLANK_FIRST_LINE,
        .PADDING_ROWS, .INTEGRATION_TIME, .PERIOD_LENGTH, .PERIOD_IS_FRAME, .TICK_MULT, .COLUMN_GAIN,
        .GS_TICK, .GS_EXPOSING, .GS_PERIOD_DONE);
    initial begin
        forever #20 CLK = ~CLK;
    end
    // ****************************************
    // model and bus tasks
    // ****************************************
    function automatic logic [15:0] kept(int o);
        case (o)
            2: return 16'h0004;
            5: return 16'h01FF;
            6: return 16'h0FFF;
            'hA, 'hB: return 16'h0000;
            default: return 16'hFFFF;
        endcase
    endfunction
    function automatic logic [15:0] dk(logic [15:0] v);
        return (v[7:0] == 8'h00) ? 16'h0001 : {8'h00, v[7:0]};
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input int o, input logic [15:0] d);
        @(posedge CLK) #1;
        CFG_WR = 1;
        CFG_ADDR = BANK_BASE + 9'(o);
        CFG_WDATA = d;
        @(posedge CLK) #1;
        CFG_WR = 0;
        if (mdl.exists(o)) mdl[o] = d & kept(o);
    endtask
    task automatic rd(input int o);
        @(posedge CLK) #1;
        CFG_RD = 1;
        CFG_ADDR = BANK_BASE + 9'(o);
        @(posedge CLK) #1;
        CFG_RD = 0;
        check(CFG_RVALID, 16'h0001);
        check(CFG_RDATA, mdl.exists(o) ? mdl[o] : 16'h0000);
    endtask
    task automatic pulse_frame;
        @(posedge CLK) #1;
        FRAME_START = 1;
        @(posedge CLK) #1;
        FRAME_START = 0;
        repeat (2) @(posedge CLK);
        #1;
    endtask
    task automatic check_app;
        check(REGION_ENABLE_UPPER, mdl[4][15:7]);
        check(DARK_ROWS, dk(mdl[5]));
        check(BLANK_FIRST_LINE, mdl[5][8]);
        check(PADDING_ROWS, GLOBAL_SHUTTER ? 16'h0000 : mdl[6][11:0]);
        check(TICK_MULT, mdl[7]);
        check(PERIOD_LENGTH, mdl[8]);
        check(INTEGRATION_TIME, mdl[9]);
        check(PERIOD_IS_FRAME, mdl[2][2]);
        check(COLUMN_GAIN, mdl['hC][4:0]);
    endtask
    task final_report;
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(85030));
        mdl = '{2: 16'h0004, 4: 16'h0000, 5: 16'h0102, 6: 16'h0000, 7: 16'h0001, 8: 16'h0000,
                9: 16'h0000, 'hA: 16'h0000, 'hB: 16'h0000, 'hC: 16'h01E2, 'hE: 16'h033F};
        repeat (5) @(posedge CLK);
        #1 SRST = 0;
        check_app;
        foreach (offs[i]) rd(offs[i]);
        rd('hD);
        rd('h30);
        // random words, all but the gain word applied only at frame start while sync bits stay set
        for (int r = 0; r < 6; r++) begin
            GLOBAL_SHUTTER = r[0];
            hold_d = dk(mdl[5]);
            hold_i = mdl[9];
            foreach (offs[i]) if (offs[i] != 'hE) wr(offs[i], 16'($urandom) & kept(offs[i]));
            if (r == 0) wr(5, 16'h0100);
            if (r == 1) wr(5, 16'h00FF);
            check(DARK_ROWS, hold_d);
            check(INTEGRATION_TIME, hold_i);
            pulse_frame;
            check_app;
            foreach (offs[i]) rd(offs[i]);
        end
        // sync bits cleared: values follow the registers without a frame start
        GLOBAL_SHUTTER = 0;
        wr('hE, 16'h0000);
        wr(5, 16'h0005);
        wr(4, 16'hFF80);
        wr(9, 16'h1234);
        wr(6, 16'h0ABC);
        repeat (3) @(posedge CLK);
        #1;
        check_app;
        wr('hE, 16'h033F);
        // global shutter sequence in both period meanings, then a refused start
        for (int m = 0; m < 3; m++) begin
            GLOBAL_SHUTTER = (m < 2);
            wr(2, m[0] ? 16'h0004 : 16'h0000);
            wr(7, 16'h0005);
            wr(8, m[0] ? 16'd10 : 16'd3);
            wr(9, 16'd3);
            pulse_frame;
            @(posedge CLK) #1;
            GS_START = 1;
            @(posedge CLK) #1;
            GS_START = 0;
            tall = 0;
            tex = 0;
            tdone = -1;
            tfirst = -1;
            tlast = -1;
            tprev = 0;
            // ticks of the start and done pipeline at both ends are not counted
            for (cyc = 0; cyc < 120; cyc++) begin
                @(posedge CLK) #1;
                if (GS_PERIOD_DONE === 1'b1 && tdone < 0) begin
                    tdone = cyc;
                    tall -= tprev;
                end
                if (GS_TICK === 1'b1 && tdone < 0 && cyc > 0) tall++;
                tprev = (GS_TICK === 1'b1 && cyc > 0);
                if (GS_EXPOSING === 1'b1) begin
                    tex += (GS_TICK === 1'b1);
                    if (tfirst < 0) tfirst = cyc;
                    tlast = cyc;
                end
            end
            if (m < 2) begin
                check(16'(tdone >= 0 && tall >= mdl[8] - 1 && tall <= mdl[8] + 1), 16'h0001);
                check(16'(tex >= 2 && tex <= 4), 16'h0001);
                check(16'(m ? tdone > tlast : tdone < tfirst && tfirst >= 0), 16'h0001);
            end else begin
                check(16'(tfirst < 0 && tdone < 0), 16'h0001);
            end
        end
        final_report;
    end
    initial begin
        #(40 * 10000);
        errors++;
        final_report;
    end
endmodule
bind sftr_frame_timing_regs sftr_ftr_monitor u_mon (.CLK(CLK), .SRST(SRST), .CFG_RD(CFG_RD),
    .CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA), .CFG_RVALID(CFG_RVALID), .GLOBAL_SHUTTER(GLOBAL_SHUTTER),
    .REGION_ENABLE_UPPER(REGION_ENABLE_UPPER), .DARK_ROWS(DARK_ROWS), .BLANK_FIRST_LINE(BLANK_FIRST_LINE),
    .PADDING_ROWS(PADDING_ROWS), .PERIOD_IS_FRAME(PERIOD_IS_FRAME), .TICK_MULT(TICK_MULT),
    .GS_TICK(GS_TICK), .GS_PERIOD_DONE(GS_PERIOD_DONE));
`default_nettype wire
